// file: ref_clock_pin_pkg.sv
/*
 * Constants for the reference clock output block: register addresses,
 * field positions, reset values and divider sizing.
 * Assumes a plain register port with a 12-bit address.
 */
//
// Summary of operation
// - Pin driven only while output enable set.
// - Output works in every oscillator configuration while awake.
// - Four-bit divisor selects sixteen divide ratios.
// - Divide base by two to divisor code.
// - Source bit picks primary oscillator, else system.
// - Sleep-run bit keeps primary-sourced output alive in Sleep in kept modes.
// - Sleep output needs sleep-run and source set.
// - Primary oscillator off in Sleep unless kept.
package ref_clock_pin_pkg;

    // ****************************************************************
    // Register map
    // ****************************************************************
    localparam int          ADDR_W       = 12;
    localparam logic [11:0] ADDR_CTRL    = 12'hf3d;
    localparam logic [11:0] ADDR_STATUS  = 12'hf3e;

    // ****************************************************************
    // Control fields
    // ****************************************************************
    localparam int          BIT_ENABLE   = 7;
    localparam int          BIT_SLEEPRUN = 5;
    localparam int          BIT_SOURCE   = 4;
    localparam int          DIV_LSB      = 0;
    localparam int          DIV_W        = 4;
    localparam logic [7:0]  CTRL_MASK    = 8'hbf;
    localparam logic [7:0]  CTRL_RESET   = 8'h00;

    // ****************************************************************
    // Status fields
    // ****************************************************************
    localparam int          BIT_ST_DRIVE = 0;
    localparam int          BIT_ST_LEVEL = 1;
    localparam int          BIT_ST_PRION = 2;

    // ****************************************************************
    // Divider and oscillator configuration
    // ****************************************************************
    localparam int          CNT_W        = 15;
    localparam int          OSC_CFG_W    = 3;
    localparam logic [7:0]  KEEP_MASK_DEF = 8'hf0;

endpackage : ref_clock_pin_pkg

// file: ref_clock_pin_divider.sv
/*
 * Power-of-two divider of a sampled base clock level.
 * Assumes the base level is synchronous to mclk and slower than mclk/2.
 */
`timescale 1ns/1ns
module ref_clock_pin_divider #(
    parameter int DIV_W = ref_clock_pin_pkg::DIV_W,
    parameter int CNT_W = ref_clock_pin_pkg::CNT_W
) (
    // Clock and reset
    input  wire logic             mclk,
    input  wire logic             arst_n,
    // Control
    input  wire logic             clear,
    input  wire logic [DIV_W-1:0] div_sel,
    // Clock in and out
    input  wire logic             base_level,
    output logic                  div_out
);

    initial begin
        if (CNT_W != (2 ** DIV_W) - 1)
            $error("ref_clock_pin_divider: CNT_W must be 2**DIV_W-1");
    end

    logic             base_prev;
    logic [CNT_W-1:0] cnt;
    logic             rise;

    assign rise = base_level & ~base_prev;

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n)
            base_prev <= 1'b0;
        else
            base_prev <= base_level;
    end

    // ****************************************************************
    // Edge counter; bit n-1 has period 2**n base periods
    // ****************************************************************
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n)
            cnt <= '0;
        else if (clear)
            cnt <= '0;
        else if (rise)
            cnt <= cnt + CNT_W'(1);
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n)
            div_out <= 1'b0;
        else if (clear)
            div_out <= 1'b0;
        else if (div_sel == '0)
            div_out <= base_level;
        else
            div_out <= cnt[div_sel - DIV_W'(1)];
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    property p_div_pass;
        @(posedge mclk) disable iff (!arst_n)
        (div_sel == '0 && !clear) |=> (div_out == $past(base_level));
    endproperty
    a_div_pass: assert property (p_div_pass)
        else $error("divide by one does not follow base");

    property p_div_count;
        @(posedge mclk) disable iff (!arst_n)
        (rise && !clear) |=> (cnt == $past(cnt) + CNT_W'(1));
    endproperty
    a_div_count: assert property (p_div_count)
        else $error("edge counter missed a base rising edge");

    property p_div_clear;
        @(posedge mclk) disable iff (!arst_n)
        clear |=> (cnt == '0 && !div_out);
    endproperty
    a_div_clear: assert property (p_div_clear)
        else $error("divider not cleared");

endmodule : ref_clock_pin_divider

// file: ref_clock_pin_top.sv
/*
 * Reference clock output: control and status registers, source and
 * Sleep gating, and the output pin drive.
 * Assumes base clock levels and sleep state synchronous to mclk.
 */
// Design decision made here: strobed register access.
`timescale 1ns/1ns
module ref_clock_pin_top #(
    parameter logic [7:0] KEEP_MASK = ref_clock_pin_pkg::KEEP_MASK_DEF
) (
    // Clock and reset
    input  wire logic                           mclk,
    input  wire logic                           arst_n,
    // Register port
    input  wire logic [ref_clock_pin_pkg::ADDR_W-1:0]    reg_addr,
    input  wire logic [7:0]                     reg_wdata,
    input  wire logic                           reg_write,
    input  wire logic                           reg_read,
    output logic      [7:0]                     reg_rdata,
    // Base clocks
    input  wire logic                           base_sys_clk,
    input  wire logic                           base_pri_clk,
    // Power state and oscillator configuration
    input  wire logic                           sleep_mode,
    input  wire logic [ref_clock_pin_pkg::OSC_CFG_W-1:0] oscillator_config_field,
    output logic                                pri_osc_on,
    // Reference clock pin
    output logic                                ref_clock_pin_out,
    output logic                                ref_clock_pin_oe
);

    localparam int DW = ref_clock_pin_pkg::DIV_W;

    logic [7:0]    reference_output_control;
    logic          ref_output_enable;
    logic          ref_run_in_sleep;
    logic          ref_base_source_select;
    logic [DW-1:0] ref_divisor_select;
    logic          keep_in_sleep;
    logic          active;
    logic          base_level;
    logic          div_out;
    logic [7:0]    status;

    // ****************************************************************
    // Helper functions
    // ****************************************************************
    function automatic logic osc_kept(input logic [7:0] mask,
                                      input logic [ref_clock_pin_pkg::OSC_CFG_W-1:0] cfg);
        osc_kept = mask[cfg];
    endfunction : osc_kept

    function automatic logic addr_hit(input logic [ref_clock_pin_pkg::ADDR_W-1:0] a,
                                      input logic [ref_clock_pin_pkg::ADDR_W-1:0] b);
        addr_hit = (a == b);
    endfunction : addr_hit

    // ****************************************************************
    // Control register
    // ****************************************************************
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n)
            reference_output_control <= ref_clock_pin_pkg::CTRL_RESET;
        else if (reg_write && addr_hit(reg_addr, ref_clock_pin_pkg::ADDR_CTRL))
            reference_output_control <= reg_wdata & ref_clock_pin_pkg::CTRL_MASK;
    end

    assign ref_output_enable      = reference_output_control[ref_clock_pin_pkg::BIT_ENABLE];
    assign ref_run_in_sleep       = reference_output_control[ref_clock_pin_pkg::BIT_SLEEPRUN];
    assign ref_base_source_select = reference_output_control[ref_clock_pin_pkg::BIT_SOURCE];
    assign ref_divisor_select     = reference_output_control[ref_clock_pin_pkg::DIV_LSB +: DW];

    // ****************************************************************
    // Source, oscillator and Sleep gating
    // ****************************************************************
    // Only external-clock and high-speed crystal modes keep the primary alive
    assign keep_in_sleep = osc_kept(KEEP_MASK, oscillator_config_field);
    assign pri_osc_on    = !sleep_mode || keep_in_sleep;

    // Awake: any configuration works; asleep: both bits and a live primary
    always_comb begin
        if (!ref_output_enable)
            active = 1'b0;
        else if (!sleep_mode)
            active = 1'b1;
        else
            active = ref_run_in_sleep && ref_base_source_select
                     && keep_in_sleep;
    end

    assign base_level = ref_base_source_select ? base_pri_clk
                                               : base_sys_clk;

    ref_clock_pin_divider #(
        .DIV_W (DW),
        .CNT_W (ref_clock_pin_pkg::CNT_W)
    ) u_div (
        .mclk       (mclk),
        .arst_n     (arst_n),
        .clear      (!active),
        .div_sel    (ref_divisor_select),
        .base_level (base_level),
        .div_out    (div_out)
    );

    // ****************************************************************
    // Pin drive
    // ****************************************************************
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            ref_clock_pin_oe  <= 1'b0;
            ref_clock_pin_out <= 1'b0;
        end else begin
            ref_clock_pin_oe  <= active;
            ref_clock_pin_out <= active && div_out;
        end
    end

    // ****************************************************************
    // Read port
    // ****************************************************************
    always_comb begin
        status = 8'h00;
        status[ref_clock_pin_pkg::BIT_ST_DRIVE] = ref_clock_pin_oe;
        status[ref_clock_pin_pkg::BIT_ST_LEVEL] = ref_clock_pin_out;
        status[ref_clock_pin_pkg::BIT_ST_PRION] = pri_osc_on;
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n)
            reg_rdata <= 8'h00;
        else if (reg_read && addr_hit(reg_addr, ref_clock_pin_pkg::ADDR_CTRL))
            reg_rdata <= reference_output_control;
        else if (reg_read && addr_hit(reg_addr, ref_clock_pin_pkg::ADDR_STATUS))
            reg_rdata <= status;
        else
            reg_rdata <= 8'h00;
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    sequence s_ctrl_write;
        reg_write && reg_addr == ref_clock_pin_pkg::ADDR_CTRL;
    endsequence

    sequence s_ctrl_read;
        reg_read && reg_addr == ref_clock_pin_pkg::ADDR_CTRL;
    endsequence

    property p_disabled_off;
        @(posedge mclk) disable iff (!arst_n)
        !ref_output_enable |=> (!ref_clock_pin_oe && !ref_clock_pin_out);
    endproperty
    a_disabled_off: assert property (p_disabled_off)
        else $error("pin driven while output disabled");

    property p_awake_on;
        @(posedge mclk) disable iff (!arst_n)
        (ref_output_enable && !sleep_mode) |=> ref_clock_pin_oe;
    endproperty
    a_awake_on: assert property (p_awake_on)
        else $error("enabled output not driven while awake");

    property p_source;
        @(posedge mclk) disable iff (!arst_n)
        (ref_divisor_select == '0 && active) ##1 active
            |=> (ref_clock_pin_out == $past(base_level, 2));
    endproperty
    a_source: assert property (p_source)
        else $error("undivided output does not follow the chosen base");

    property p_sleep_stop;
        @(posedge mclk) disable iff (!arst_n)
        (sleep_mode && !ref_run_in_sleep) |=> !ref_clock_pin_oe;
    endproperty
    a_sleep_stop: assert property (p_sleep_stop)
        else $error("output runs in Sleep with sleep-run cleared");

    property p_sleep_both;
        @(posedge mclk) disable iff (!arst_n)
        (sleep_mode && ref_output_enable && keep_in_sleep)
            |=> (ref_clock_pin_oe == $past(ref_run_in_sleep && ref_base_source_select));
    endproperty
    a_sleep_both: assert property (p_sleep_both)
        else $error("Sleep output does not match sleep-run and source bits");

    property p_osc_down;
        @(posedge mclk) disable iff (!arst_n)
        (sleep_mode && !keep_in_sleep) |-> !pri_osc_on ##1 !ref_clock_pin_oe;
    endproperty
    a_osc_down: assert property (p_osc_down)
        else $error("primary alive or output driven in Sleep in an unkept mode");

    property p_write_read;
        @(posedge mclk) disable iff (!arst_n)
        s_ctrl_write ##1 s_ctrl_read
            |=> (reg_rdata == ($past(reg_wdata, 2) & ref_clock_pin_pkg::CTRL_MASK));
    endproperty
    a_write_read: assert property (p_write_read)
        else $error("control readback differs from written value");

    property p_reset_clear;
        @(posedge mclk)
        $rose(arst_n) |-> (reference_output_control == ref_clock_pin_pkg::CTRL_RESET
                           && !ref_clock_pin_oe);
    endproperty
    a_reset_clear: assert property (p_reset_clear)
        else $error("control not cleared by reset");

    // ****************************************************************
    // Register port, pin drive and oscillator checks
    // ****************************************************************
    sequence s_status_read;
        reg_read && reg_addr == ref_clock_pin_pkg::ADDR_STATUS;
    endsequence

    property p_read_ctrl;
        @(posedge mclk) disable iff (!arst_n)
        s_ctrl_read |=> (reg_rdata == $past(reference_output_control));
    endproperty
    a_read_ctrl: assert property (p_read_ctrl)
        else $error("control read returns wrong value");

    property p_read_status;
        @(posedge mclk) disable iff (!arst_n)
        s_status_read |=> (reg_rdata == $past(status));
    endproperty
    a_read_status: assert property (p_read_status)
        else $error("status read returns wrong value");

    property p_rdata_idle;
        @(posedge mclk) disable iff (!arst_n)
        !reg_read |=> (reg_rdata == 8'h00);
    endproperty
    a_rdata_idle: assert property (p_rdata_idle)
        else $error("read data not zero outside a read");

    property p_bit6_zero;
        @(posedge mclk) disable iff (!arst_n)
        !reference_output_control[6];
    endproperty
    a_bit6_zero: assert property (p_bit6_zero)
        else $error("unimplemented control bit set");

    property p_ctrl_hold;
        @(posedge mclk) disable iff (!arst_n)
        !reg_write |=> $stable(reference_output_control);
    endproperty
    a_ctrl_hold: assert property (p_ctrl_hold)
        else $error("control changed without a write");

    property p_pin_low_off;
        @(posedge mclk) disable iff (!arst_n)
        !ref_clock_pin_oe |-> !ref_clock_pin_out;
    endproperty
    a_pin_low_off: assert property (p_pin_low_off)
        else $error("pin level high while not driven");

    property p_pin_follows;
        @(posedge mclk) disable iff (!arst_n)
        active |=> (ref_clock_pin_out == $past(div_out));
    endproperty
    a_pin_follows: assert property (p_pin_follows)
        else $error("pin does not carry the divided clock");

    property p_pri_awake;
        @(posedge mclk) disable iff (!arst_n)
        !sleep_mode |-> pri_osc_on;
    endproperty
    a_pri_awake: assert property (p_pri_awake)
        else $error("primary oscillator off while awake");

    property p_pri_kept;
        @(posedge mclk) disable iff (!arst_n)
        (sleep_mode && keep_in_sleep) |-> pri_osc_on;
    endproperty
    a_pri_kept: assert property (p_pri_kept)
        else $error("primary oscillator off in a kept mode");

    property p_sys_sleep;
        @(posedge mclk) disable iff (!arst_n)
        (sleep_mode && !ref_base_source_select) |=> !ref_clock_pin_oe;
    endproperty
    a_sys_sleep: assert property (p_sys_sleep)
        else $error("system clock output runs in Sleep");

    property p_reset_fields;
        @(posedge mclk)
        $rose(arst_n) |-> (ref_divisor_select == '0 && !ref_base_source_select
                           && !ref_run_in_sleep);
    endproperty
    a_reset_fields: assert property (p_reset_fields)
        else $error("control fields not cleared by reset");

endmodule : ref_clock_pin_top

// file: rco_ext_device.sv
/*
 * External device clocked by the reference pin: counts rising edges and
 * measures the mclk cycles between the last two of them.
 * Assumes the pin is pulled low on the board while it is not driven.
 */
`timescale 1ns/1ns
module rco_ext_device (
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        arst_n,
    // Reference pin
    input  wire logic        pin_out,
    input  wire logic        pin_oe,
    // Measurements
    output logic      [31:0] edge_count,
    output logic      [31:0] last_period
);
    logic        pin_q;
    logic [31:0] since;
    logic        pin_level;

    // Pull-down wins while the pin is released
    assign pin_level = pin_oe & pin_out;

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            pin_q       <= 1'b0;
            since       <= 32'h0000_0000;
            edge_count  <= 32'h0000_0000;
            last_period <= 32'h0000_0000;
        end else begin
            pin_q <= pin_level;
            if (pin_level && !pin_q) begin
                edge_count  <= edge_count + 32'h0000_0001;
                last_period <= since + 32'h0000_0001;
                since       <= 32'h0000_0000;
            end else begin
                since <= since + 32'h0000_0001;
            end
        end
    end
endmodule : rco_ext_device

// file: rco_tb_top.sv
/*
 * Self-checking testbench of the reference clock output block.
 * Assumes the default KEEP_MASK and base clocks of mclk/4 and mclk/8.
 */
`timescale 1ns/1ns
module reference_clock_output_tb_top;
    logic        mclk = 1'b0;
    logic        arst_n = 1'b0;
    logic [11:0] reg_addr = 12'h000;
    logic [7:0]  reg_wdata = 8'h00;
    logic        reg_write = 1'b0;
    logic        reg_read = 1'b0;
    logic [7:0]  reg_rdata;
    logic [2:0]  bdiv = 3'h0;
    logic        sleep_mode = 1'b0;
    logic [2:0]  cfg = 3'h0;
    logic        pri_osc_on;
    logic        pin_out;
    logic        pin_oe;
    logic [31:0] edge_count;
    logic [31:0] last_period;
    int          err_total = 0;
    int          n_checks = 0;
    logic [7:0]  rd;

    // ****************************************************************
    // Clock, base clocks, design and far side
    // ****************************************************************
    initial begin
        forever #10 mclk = ~mclk;
    end
    always @(posedge mclk) bdiv <= bdiv + 3'h1;

    ref_clock_pin_top dut (.mclk(mclk), .arst_n(arst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .base_sys_clk(bdiv[1]), .base_pri_clk(bdiv[2]),
        .sleep_mode(sleep_mode), .oscillator_config_field(cfg),
        .pri_osc_on(pri_osc_on), .ref_clock_pin_out(pin_out),
        .ref_clock_pin_oe(pin_oe));
    rco_ext_device ext (.mclk(mclk), .arst_n(arst_n), .pin_out(pin_out),
        .pin_oe(pin_oe), .edge_count(edge_count), .last_period(last_period));

    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    task automatic test_done;
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : test_done

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic reg_wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_write <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_write <= 1'b0;
    endtask : reg_wr

    task automatic reg_rd(input logic [11:0] a, output logic [7:0] d);
        @(posedge mclk);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_read <= 1'b0;
        #1;
        d = reg_rdata;
    endtask : reg_rd

    // Checks pin drive three cycles after the inputs settle
    task automatic pin_state(input logic exp_oe);
        repeat (3) @(posedge mclk);
        #1;
        check(pin_oe, exp_oe);
        if (!exp_oe) check(pin_out, 1'b0);
    endtask : pin_state

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_regs;
        reg_rd(ref_clock_pin_pkg::ADDR_CTRL, rd);
        check(rd, 8'h00);
        reg_rd(ref_clock_pin_pkg::ADDR_STATUS, rd);
        check(rd, 8'h04);
        @(posedge mclk);
        #1;
        check(reg_rdata, 8'h00);
        pin_state(1'b0);
        reg_wr(ref_clock_pin_pkg::ADDR_CTRL, 8'hff);
        reg_rd(ref_clock_pin_pkg::ADDR_CTRL, rd);
        check(rd, 8'hbf);
        @(posedge mclk);
        reg_write <= 1'b1;
        reg_addr  <= ref_clock_pin_pkg::ADDR_CTRL;
        reg_wdata <= 8'h5a;
        @(posedge mclk);
        reg_write <= 1'b0;
        reg_read  <= 1'b1;
        @(posedge mclk);
        reg_read  <= 1'b0;
        #1;
        check(reg_rdata, 8'h1a);
        reg_rd(12'hf3f, rd);
        check(rd, 8'h00);
        reg_wr(ref_clock_pin_pkg::ADDR_CTRL, 8'h00);
        pin_state(1'b0);
    endtask : t_regs

    task automatic t_divide(input logic [3:0] d, input logic src, input logic [31:0] exp);
        int start;
        int k;
        start = edge_count;
        k = 0;
        reg_wr(ref_clock_pin_pkg::ADDR_CTRL, {1'b1, 2'b00, src, d});
        while (edge_count < start + 3 && k < 16 * exp + 40) begin
            @(posedge mclk);
            k++;
        end
        check(last_period, exp);
        reg_wr(ref_clock_pin_pkg::ADDR_CTRL, 8'h00);
    endtask : t_divide

    task automatic t_slow_code;
        int start;
        start = edge_count;
        reg_wr(ref_clock_pin_pkg::ADDR_CTRL, 8'h8f);
        repeat (4000) @(posedge mclk);
        check(edge_count, start);
        check(pin_oe, 1'b1);
        reg_wr(ref_clock_pin_pkg::ADDR_CTRL, 8'h00);
    endtask : t_slow_code

    task automatic t_modes;
        logic [3:0] c;
        reg_wr(ref_clock_pin_pkg::ADDR_CTRL, 8'h82);
        for (int m = 0; m < 8; m++) begin
            cfg <= m[2:0];
            pin_state(1'b1);
        end
        for (int i = 0; i < 8; i++) begin
            c = {i[2], 3'h3} + {3'h0, i[2]};
            reg_wr(ref_clock_pin_pkg::ADDR_CTRL, {2'b10, i[1], i[0], 4'h1});
            cfg <= c[2:0];
            sleep_mode <= 1'b1;
            pin_state(i[1] & i[0] & i[2]);
            check(pri_osc_on, i[2]);
            sleep_mode <= 1'b0;
            pin_state(1'b1);
        end
    endtask : t_modes

    task automatic t_reset_again;
        reg_wr(ref_clock_pin_pkg::ADDR_CTRL, 8'h9f);
        @(posedge mclk);
        arst_n <= 1'b0;
        repeat (2) @(posedge mclk);
        arst_n <= 1'b1;
        reg_rd(ref_clock_pin_pkg::ADDR_CTRL, rd);
        check(rd, 8'h00);
        pin_state(1'b0);
    endtask : t_reset_again

    // ****************************************************************
    // Main sequence and watchdog
    // ****************************************************************
    initial begin
        repeat (5) @(posedge mclk);
        arst_n <= 1'b1;
        t_regs();
        for (int d = 0; d <= 10; d++) t_divide(d[3:0], 1'b0, 32'h4 << d);
        t_divide(4'h0, 1'b1, 32'h0000_0008);
        t_divide(4'h2, 1'b1, 32'h0000_0020);
        t_slow_code();
        t_modes();
        t_reset_again();
        test_done();
    end

    initial begin
        #1_200_000;
        err_total++;
        test_done();
    end
endmodule : reference_clock_output_tb_top
